// >>> hw/cpu_external_bus_interface.sv
// External system bus interface: address, data and strobe sequencing
// Notes on behaviour
// - Drive 20-bit address for memory and I/O cycles.
// - Refresh cycles put the refresh address on the address lines.
// - Address lines float during reset and while the bus is granted.
// - External master accesses make the address lines inputs.
// - Bit 18 may carry the timer output; after reset it is address.
// - Data lines driven with the byte on internal peripheral accesses.
// - Read strobe driven by the core; input under an external master.
// - Write strobe low while write data valid; input under external master.
// - Memory request low only while a valid memory address is out.
// - I/O request low while I/O address is on low eight lines.
// - Interrupt acknowledge asserts I/O request with opcode-fetch strobe.
// - Opcode fetch asserts opcode-fetch and memory request together.
// - Each opcode byte of a two-byte opcode gets its own fetch strobe.
// - Fetch strobe, halt and status together encode the cycle kind.
// - Refresh strobe with memory request while refresh address is out.
// - Bus request honoured at cycle end; bus and strobes float.
// - Bus acknowledge asserted after the bus has floated.
// - Wait input stretches the strobe phase while held low; refresh and interrupt acknowledge cycles ignore it.
`timescale 1ns/1ns
module cpu_external_bus_interface #(
  parameter int AW = ext_bus_pkg::ADDR_W,
  parameter int DW = ext_bus_pkg::DATA_W
) (
  input wire logic i_clk, // 20 MHz clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic i_req, // Core starts a bus cycle
  input wire ext_bus_pkg::cyc_kind_t i_kind, // Cycle kind
  input wire logic [AW-1:0] i_addr, // Cycle address
  input wire logic [DW-1:0] i_wdata, // Write data
  input wire logic i_internal, // Target is an on-chip peripheral
  input wire logic i_halted, // Core halted
  input wire logic i_timer_sel, // Bit 18 pin carries timer output
  input wire logic i_timer_out, // Timer channel output
  input wire logic i_bus_grant_request_n, // Bus request, active low
  input wire logic i_wait_n, // Wait input, active low
  input wire logic [AW-1:0] i_system_address_lines, // Address pin input
  input wire logic [DW-1:0] i_system_data_lines, // Data pin input
  input wire logic i_rd_n, // Read pin input
  input wire logic i_wr_n, // Write pin input
  output logic o_ready, // Core may issue a request
  output logic o_done, // Cycle done pulse
  output logic [DW-1:0] o_rdata, // Read data
  output logic o_ext_access, // External master strobing on-chip target
  output logic [AW-1:0] o_ext_addr, // Address seen from external master
  output logic [AW-1:0] o_system_address_lines, // Address pin output
  output logic o_addr_oe_n, // Address enable, low drives
  output logic [DW-1:0] o_system_data_lines, // Data pin output
  output logic o_data_oe_n, // Data enable, low drives
  output logic o_rd_n, // Read strobe
  output logic o_wr_n, // Write strobe
  output logic o_strobe_oe_n, // Strobe enable, low drives
  output logic o_memory_request_n, // Memory request strobe
  output logic o_io_request_n, // I/O request strobe
  output logic o_opcode_fetch_cycle_n, // Opcode fetch strobe
  output logic o_refresh_strobe_n, // Refresh strobe
  output logic o_halt_n, // Halt status
  output logic o_cycle_status_out, // Cycle status
  output logic o_bus_grant_ack_n // Bus acknowledge
);
  import ext_bus_pkg::*;

  // Elaboration check: the pin map and the bit 18 multiplex assume these widths
  if (AW != ADDR_W || DW != DATA_W || AW <= TIMER_PIN_BIT) begin : g_bad_width
    $error("Unsupported bus widths");
  end


  bus_state_t state_r, state_nxt;
  cyc_kind_t kind_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic internal_r;
  logic ack_n_r;
  logic done_r;
  logic [DW-1:0] rdata_r;

  // Kind decode of the latched cycle
  wire is_mem = (kind_r == CYC_MEM_RD) || (kind_r == CYC_MEM_WR);
  wire is_io = (kind_r == CYC_IO_RD) || (kind_r == CYC_IO_WR);
  wire is_fetch = (kind_r == CYC_FETCH);
  wire is_intack = (kind_r == CYC_INTACK);
  wire is_refresh_strobe_n = (kind_r == CYC_REFRESH);
  wire is_read = (kind_r == CYC_MEM_RD) || (kind_r == CYC_IO_RD) || is_fetch;
  wire is_write = (kind_r == CYC_MEM_WR) || (kind_r == CYC_IO_WR);
  wire busy = (state_r == ST_ADDR) || (state_r == ST_STROBE) || (state_r == ST_END);
  wire grant = (state_r == ST_GRANT);
  wire brq = ~i_bus_grant_request_n;

  // Phase sequencing; a grant is only taken between cycles
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (brq) begin
          state_nxt = ST_GRANT;
        end else if (i_req) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: state_nxt = ST_STROBE;
      ST_STROBE: begin
        if (i_wait_n || is_refresh_strobe_n || is_intack) begin
          state_nxt = ST_END;
        end
      end
      ST_END: state_nxt = brq ? ST_GRANT : ST_IDLE;
      ST_GRANT: state_nxt = brq ? ST_GRANT : ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Latch the cycle at its start so the pins stay stable during it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      kind_r <= CYC_MEM_RD;
      addr_r <= '0;
      wdata_r <= '0;
      internal_r <= 1'b0;
    end else if (i_ce) begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && !brq && i_req) begin
        kind_r <= i_kind;
        addr_r <= i_addr;
        wdata_r <= i_wdata;
        internal_r <= i_internal;
      end
    end
  end

  // Read data, done pulse, acknowledge after the bus already floats
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      done_r <= 1'b0;
      rdata_r <= '0;
      ack_n_r <= 1'b1;
    end else if (i_ce) begin
      done_r <= (state_r == ST_END);
      if (state_r == ST_STROBE && state_nxt == ST_END && (is_read || is_intack)) begin
        rdata_r <= i_system_data_lines;
      end
      ack_n_r <= ~(grant && brq);
    end
  end

  // Next pin values; strobes only in strobe phase so address leads and trails
  wire drive_bus = busy || (state_r == ST_IDLE && !brq && i_req);
  wire [AW-1:0] addr_src = (state_r == ST_IDLE) ? i_addr : addr_r;
  wire [AW-1:0] io_addr = {{(AW-IO_ADDR_W){1'b0}}, addr_src[IO_ADDR_W-1:0]};
  wire kind_io_nxt = (state_r == ST_IDLE) ? (i_kind == CYC_IO_RD || i_kind == CYC_IO_WR) : is_io;
  wire [AW-1:0] addr_mux = kind_io_nxt ? io_addr : addr_src;
  wire timer_pin = i_timer_sel ? i_timer_out : addr_mux[TIMER_PIN_BIT];
  wire [AW-1:0] addr_pin_nxt = {addr_mux[AW-1:TIMER_PIN_BIT+1], timer_pin,
    addr_mux[TIMER_PIN_BIT-1:0]};
  // Address must not trail into a grant, or it would fight the external master
  wire addr_drive_nxt = drive_bus && (state_nxt != ST_GRANT);
  wire ph_next_strobe = (state_nxt == ST_STROBE);
  wire memory_request_n_nxt = ph_next_strobe && (is_mem || is_fetch || is_refresh_strobe_n);
  wire io_request_n_nxt = ph_next_strobe && (is_io || is_intack);
  wire m1_nxt = ph_next_strobe && (is_fetch || is_intack);
  wire refresh_strobe_n_nxt = ph_next_strobe && is_refresh_strobe_n;
  wire rd_nxt = ph_next_strobe && is_read;
  wire wr_nxt = ph_next_strobe && is_write;
  wire data_drive_nxt = (state_nxt == ST_STROBE || state_nxt == ST_END) && internal_r
    && (is_write || is_read) && !grant;
  wire [DW-1:0] data_val_nxt = is_write ? wdata_r : rdata_r;
  wire strobe_drive_nxt = !(state_nxt == ST_GRANT);

  pin_drive_reg #(.W(AW)) u_addr_pins (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_val(addr_pin_nxt),
    .i_drive(addr_drive_nxt),
    .o_val(o_system_address_lines),
    .o_oe_n(o_addr_oe_n)
  );

  pin_drive_reg #(.W(DW)) u_data_pins (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_val(data_val_nxt),
    .i_drive(data_drive_nxt),
    .o_val(o_system_data_lines),
    .o_oe_n(o_data_oe_n)
  );

  pin_drive_reg #(.W(6), .RST_VAL(6'h3f)) u_strobes (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_val({~rd_nxt, ~wr_nxt, ~memory_request_n_nxt, ~io_request_n_nxt, ~m1_nxt, ~refresh_strobe_n_nxt}),
    .i_drive(strobe_drive_nxt),
    .o_val({o_rd_n, o_wr_n, o_memory_request_n, o_io_request_n, o_opcode_fetch_cycle_n,
      o_refresh_strobe_n}),
    .o_oe_n(o_strobe_oe_n)
  );

  // Status pins: fetch strobe plus halt and status encode the cycle kind
  logic halt_n_r, status_r;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      halt_n_r <= 1'b1;
      status_r <= 1'b0;
    end else if (i_ce) begin
      halt_n_r <= ~i_halted;
      status_r <= (state_nxt == ST_STROBE) && (is_fetch || is_intack);
    end
  end

  // External master reaching on-chip targets through input pins
  assign o_ext_access = grant && (!i_rd_n || !i_wr_n);
  assign o_ext_addr = i_system_address_lines;
  assign o_ready = (state_r == ST_IDLE) && !brq;
  assign o_done = done_r;
  assign o_rdata = rdata_r;
  assign o_halt_n = halt_n_r;
  assign o_cycle_status_out = status_r;
  assign o_bus_grant_ack_n = ack_n_r;

  property p_memory_request_n_addr;
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_memory_request_n |-> !o_addr_oe_n;
  endproperty
  a_memory_request_n_addr: assert property (p_memory_request_n_addr) else $error("memory_request_n without address");

  property p_fetch_pair;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!o_opcode_fetch_cycle_n && o_io_request_n) |-> !o_memory_request_n;
  endproperty
  a_fetch_pair: assert property (p_fetch_pair) else $error("fetch without memory_request_n");

  property p_intack;
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_io_request_n && !o_opcode_fetch_cycle_n |-> o_memory_request_n;
  endproperty
  a_intack: assert property (p_intack) else $error("intack with memory_request_n");

  property p_refresh_strobe_n;
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_refresh_strobe_n |-> !o_memory_request_n && o_rd_n && o_wr_n;
  endproperty
  a_refresh_strobe_n: assert property (p_refresh_strobe_n) else $error("refresh without memory_request_n");

  property p_reset_float;
    @(posedge i_clk) !i_rst_n |=> o_addr_oe_n && o_strobe_oe_n;
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("bus driven in reset");

  property p_ack_float;
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_bus_grant_ack_n |-> o_addr_oe_n && o_data_oe_n && o_strobe_oe_n;
  endproperty
  a_ack_float: assert property (p_ack_float) else $error("ack while driving");

  property p_wait;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && state_r == ST_STROBE && !i_wait_n && (is_read || is_write)) |=> state_r == ST_STROBE;
  endproperty
  a_wait: assert property (p_wait) else $error("wait ignored");

  property p_io_low;
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_io_request_n && o_opcode_fetch_cycle_n |-> o_system_address_lines[AW-1:IO_ADDR_W] == '0
      || i_timer_sel;
  endproperty
  a_io_low: assert property (p_io_low) else $error("io address high bits");

  property p_wr_data;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!o_wr_n && internal_r) |-> !o_data_oe_n && o_system_data_lines == wdata_r;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not driven");

  property p_io_no_memory_request_n;
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_io_request_n |-> o_memory_request_n;
  endproperty
  a_io_no_memory_request_n: assert property (p_io_no_memory_request_n) else $error("io with memory_request_n");

  property p_strobe_addr;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!o_strobe_oe_n && (!o_rd_n || !o_wr_n)) |-> !o_addr_oe_n;
  endproperty
  a_strobe_addr: assert property (p_strobe_addr) else $error("strobe without address");

  property p_grant_float;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_GRANT) |-> o_addr_oe_n && o_data_oe_n && o_strobe_oe_n;
  endproperty
  a_grant_float: assert property (p_grant_float) else $error("bus driven in grant");

  property p_timer_pin;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && i_timer_sel) |=> o_system_address_lines[TIMER_PIN_BIT] == $past(i_timer_out);
  endproperty
  a_timer_pin: assert property (p_timer_pin) else $error("timer not on bit 18");
endmodule // cpu_external_bus_interface

// >>> hw/ext_bus_pkg.sv
// Package with cycle kinds, widths and constants of the external bus interface
package ext_bus_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int IO_ADDR_W = 8;
  localparam int TIMER_PIN_BIT = 18;
  localparam logic TIMER_SEL_RST = 1'b0;
  // Cycle kinds requested by the core
  typedef enum logic [2:0] {
    CYC_MEM_RD = 3'h0,
    CYC_MEM_WR = 3'h1,
    CYC_IO_RD = 3'h2,
    CYC_IO_WR = 3'h3,
    CYC_FETCH = 3'h4,
    CYC_INTACK = 3'h5,
    CYC_REFRESH = 3'h6
  } cyc_kind_t;
  // Bus phases, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_STROBE = 5'h04,
    ST_END = 5'h08,
    ST_GRANT = 5'h10
  } bus_state_t;
endpackage

// >>> hw/pin_drive_reg.sv
// Registered output value with separate active-low drive enable for a pin group
`timescale 1ns/1ns
module pin_drive_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Sync reset
  input wire logic i_ce, // Clock enable
  input wire logic [W-1:0] i_val, // Next pin value
  input wire logic i_drive, // Next drive request
  output logic [W-1:0] o_val, // Registered pin value
  output logic o_oe_n // Registered enable, low drives
);
  // Value and enable change on the same edge so a pin never glitches
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_val <= RST_VAL;
      o_oe_n <= 1'b1;
    end else if (i_ce) begin
      o_val <= i_val;
      o_oe_n <= ~i_drive;
    end
  end
endmodule // pin_drive_reg

// >>> tb/cpu_external_bus_interface_bench.sv
// Self-checking bench for the external bus interface
`timescale 1ns/1ns
module cpu_external_bus_interface_bench;
  import ext_bus_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, inl = 1'b0, tsel = 1'b0, timer_channel_output = 1'b0;
  logic breq_n = 1'b1, xrd_n = 1'b1, xwr_n = 1'b1, hlt_in = 1'b0, ce = 1'b1;
  cyc_kind_t kind = CYC_MEM_RD;
  logic [19:0] adr = 20'h0, xadr = 20'h0, sa;
  logic [7:0] wd = 8'h0, sd;
  logic [3:0] nw = 4'h0;
  logic [5:0] msk;
  logic sdoe, sst;
  int failures = 0, n_compared = 0, lat;
  wire [19:0] a_o, a_i, ea;
  wire [7:0] d_o, d_i, m_d, rdat;
  wire a_oe, d_oe, s_oe, rd_o, wr_o, mq, iq, m1, rf, st, ack, rdy, dn, ext, w_n, hlt;
  // Wire levels resolved from the device's drive enables only
  assign a_i = a_oe ? xadr : a_o;
  assign d_i = d_oe ? m_d : d_o;
  always #25 clk = ~clk;
  cpu_external_bus_interface dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_req(req),
    .i_kind(kind), .i_addr(adr), .i_wdata(wd), .i_internal(inl), .i_halted(hlt_in),
    .i_timer_sel(tsel), .i_timer_out(timer_channel_output), .i_bus_grant_request_n(breq_n), .i_wait_n(w_n),
    .i_system_address_lines(a_i), .i_system_data_lines(d_i), .i_rd_n(s_oe ? xrd_n : rd_o),
    .i_wr_n(s_oe ? xwr_n : wr_o), .o_ready(rdy), .o_done(dn), .o_rdata(rdat),
    .o_ext_access(ext), .o_ext_addr(ea), .o_system_address_lines(a_o), .o_addr_oe_n(a_oe),
    .o_system_data_lines(d_o), .o_data_oe_n(d_oe), .o_rd_n(rd_o), .o_wr_n(wr_o),
    .o_strobe_oe_n(s_oe), .o_memory_request_n(mq), .o_io_request_n(iq),
    .o_opcode_fetch_cycle_n(m1), .o_refresh_strobe_n(rf), .o_halt_n(hlt),
    .o_cycle_status_out(st), .o_bus_grant_ack_n(ack));
  ext_target_model mdl_u (.i_clk(clk), .i_addr(a_i), .i_addr_oe_n(a_oe), .i_rd_n(rd_o | s_oe),
    .i_req_n(mq & iq), .i_waits(nw), .o_data(m_d), .o_wait_n(w_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One core cycle; records strobes, address and data seen in the strobe phase
  task automatic run(input cyc_kind_t k, input logic [19:0] a, input logic [7:0] d,
      input logic i);
    lat = 0;
    msk = 6'h0;
    sst = 1'b0;
    while (!rdy && lat < 20) begin
      @(posedge clk) #1;
      lat++;
    end
    kind = k;
    adr = a;
    wd = d;
    inl = i;
    req = 1'b1;
    @(posedge clk) #1;
    req = 1'b0;
    lat = 0;
    do begin
      @(posedge clk) #1;
      lat++;
      if (!(mq && iq && m1 && rf)) begin
        msk = msk | ~{mq, iq, m1, rf, rd_o, wr_o};
        sa = a_o;
        sd = d_o;
        sdoe = d_oe;
        sst = sst | st;
      end
    end while (!dn && lat < 30);
    chk(dn, 1'b1, "cycle done");
  endtask
  task automatic t_mem;
    run(CYC_MEM_RD, 20'hf2a51, 8'h00, 1'b0);
    chk(lat, 3, "read latency");
    chk(sa, 20'hf2a51, "mem address");
    chk(msk, 6'b100010, "mem read strobes");
    chk(rdat, 8'h51 ^ 8'h3c, "read byte");
    chk(sst, 1'b0, "status outside fetch");
    run(CYC_MEM_WR, 20'h0b00e, 8'h6d, 1'b1);
    chk(msk, 6'b100001, "mem write strobes");
    chk({sdoe, sd}, 9'h06d, "internal write data");
  endtask
  task automatic t_io;
    run(CYC_IO_WR, 20'hfff9e, 8'h11, 1'b0);
    chk(sa, 20'h0009e, "io address");
    chk(msk, 6'b010001, "io write strobes");
    run(CYC_IO_RD, 20'h00033, 8'h00, 1'b0);
    chk(msk, 6'b010010, "io read strobes");
  endtask
  task automatic t_fetch;
    repeat (2) begin
      run(CYC_FETCH, 20'h1cd00, 8'h00, 1'b0);
      chk(msk & 6'b111000, 6'b101000, "fetch strobes");
      chk(sst, 1'b1, "fetch status");
    end
    run(CYC_INTACK, 20'h00000, 8'h00, 1'b0);
    chk(msk & 6'b111000, 6'b011000, "intack strobes");
    run(CYC_REFRESH, 20'h000c7, 8'h00, 1'b0);
    chk(msk & 6'b111100, 6'b100100, "refresh strobes");
    chk(sa[7:0], 8'hc7, "refresh address");
  endtask
  task automatic t_wait;
    nw = 4'h3;
    run(CYC_MEM_RD, 20'h40010, 8'h00, 1'b0);
    chk(lat, 6, "wait latency");
    nw = 4'h0;
    tsel = 1'b1;
    timer_channel_output = 1'b1;
    run(CYC_MEM_RD, 20'h00100, 8'h00, 1'b0);
    chk(sa[18], 1'b1, "timer on bit 18");
    tsel = 1'b0;
    ce = 1'b0;
    hlt_in = 1'b1;
    @(posedge clk) #1;
    chk(hlt, 1'b1, "halt frozen while disabled");
    ce = 1'b1;
    @(posedge clk) #1;
    chk(hlt, 1'b0, "halt status");
    hlt_in = 1'b0;
  endtask
  task automatic t_grant;
    breq_n = 1'b0;
    lat = 0;
    while (ack && lat < 10) begin
      @(posedge clk) #1;
      lat++;
    end
    chk({ack, a_oe, d_oe, s_oe}, 4'b0111, "bus floated and acked");
    xadr = 20'h000a5;
    xrd_n = 1'b0;
    @(posedge clk) #1;
    chk({ext, ea}, {1'b1, 20'h000a5}, "external access");
    xrd_n = 1'b1;
    breq_n = 1'b1;
  endtask
  task automatic test_done;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence: reset, then every scenario
  initial begin
    repeat (3) @(posedge clk);
    #1;
    chk({a_oe, d_oe, s_oe, ack}, 4'hf, "floated in reset");
    rst_n = 1'b1;
    t_mem;
    t_io;
    t_fetch;
    t_wait;
    t_grant;
    test_done;
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    test_done;
  end
endmodule // cpu_external_bus_interface_bench

// >>> tb/ext_target_model.sv
// Memory and I/O target model on the far side of the external bus
`timescale 1ns/1ns
module ext_target_model (
  input wire logic i_clk, // Clock
  input wire logic [19:0] i_addr, // Address wire
  input wire logic i_addr_oe_n, // Low while device drives address
  input wire logic i_rd_n, // Read wire
  input wire logic i_req_n, // Memory or I/O request, low active
  input wire logic [3:0] i_waits, // Wait cycles to insert
  output logic [7:0] o_data, // Data wire from target
  output logic o_wait_n // Wait, low active
);
  logic [7:0] last_r = 8'h00;
  logic [3:0] cnt_r = 4'h0;
  wire drive = !i_addr_oe_n && !i_rd_n;
  // Released lines flip so a stale byte never looks valid
  assign o_data = drive ? (i_addr[7:0] ^ 8'h3c) : ~last_r;
  assign o_wait_n = i_req_n || (cnt_r >= i_waits);
  // Track last byte and how long the request has stood
  always @(posedge i_clk) begin
    if (drive) last_r <= o_data;
    cnt_r <= i_req_n ? 4'h0 : cnt_r + 4'h1;
  end
endmodule // ext_target_model
